// File: hdl/cfg_regs_pkg.sv
// Constants for the indirect configuration register bank.
// Assumes a single 40 MHz clock domain.
package cfg_regs_pkg;
  localparam logic [2:0] IDX_BYTE_COUNT   = 3'h0;
  localparam logic [2:0] IDX_OWN_ID       = 3'h1;
  localparam logic [2:0] IDX_SCL_LOW      = 3'h2;
  localparam logic [2:0] IDX_SCL_HIGH     = 3'h3;
  localparam logic [2:0] IDX_TIMEOUT      = 3'h4;
  localparam logic [2:0] IDX_RESET_KEY    = 3'h5;
  localparam logic [2:0] IDX_SPEED        = 3'h6;
  localparam logic [7:0] OWN_ID_RESET     = 8'hE0;
  localparam logic [7:0] ZERO_BYTE        = 8'h00;
  localparam logic [6:0] MAX_LENGTH       = 7'h44;
  localparam logic [6:0] ZERO_LENGTH      = 7'h00;
  localparam logic [7:0] KEY_FIRST        = 8'hA5;
  localparam logic [7:0] KEY_SECOND       = 8'h5A;
  localparam logic [7:0] STATUS_BUS_ERROR = 8'h78;
  localparam int         TOP_BIT          = 7;
  localparam logic [1:0] SPEED_STANDARD   = 2'b00;
  localparam logic [1:0] SPEED_FAST       = 2'b01;
  localparam logic [1:0] SPEED_FAST_PLUS  = 2'b10;
  localparam logic [1:0] SPEED_TURBO      = 2'b11;
  // Minimum SCL low / high counts per speed class
  localparam logic [7:0] MIN_LOW_STD  = 8'h9D;
  localparam logic [7:0] MIN_HIGH_STD = 8'h86;
  localparam logic [7:0] MIN_LOW_FM   = 8'h2C;
  localparam logic [7:0] MIN_HIGH_FM  = 8'h14;
  localparam logic [7:0] MIN_LOW_FMP  = 8'h11;
  localparam logic [7:0] MIN_HIGH_FMP = 8'h09;
  localparam logic [7:0] MIN_LOW_TRB  = 8'h0E;
  localparam logic [7:0] MIN_HIGH_TRB = 8'h05;
  // Timing: oscillator tick 35 ns, timeout unit 143.36 us
  localparam int CLK_PERIOD_PS    = 25000;
  localparam int OSC_PERIOD_PS    = 35000;
  localparam int TO_UNIT_PS       = 143360000;
  localparam int OSC_CYCLES       = OSC_PERIOD_PS / CLK_PERIOD_PS;
  localparam int TO_UNIT_CYCLES   = TO_UNIT_PS / CLK_PERIOD_PS;
endpackage : cfg_regs_pkg

// File: hdl/i2c_ctrl_indirect_config_regs.sv
// Indirect configuration registers of a parallel-bus to serial-bus controller.
// Assumes the host pointer selects idx, and wr/rd strobes are one-cycle pulses
// from logic on clk; scl_in comes from the pin and is synchronised here.
//
// Overview of operation
// RULE_01 - Buffered transmit sends transfer_length bytes, at most 68.
// RULE_02 - Buffered receive reports stored byte count in transfer_length.
// RULE_03 - Length zero or above 44h: no transfer, immediate interrupt, buffered only.
// RULE_04 - Buffered receive: final_byte_nack set withholds last ack, clear acks it.
// RULE_05 - Host ends read later by not acknowledging when final_byte_nack clear.
// RULE_06 - Host avoids byte count register while in byte mode.
// RULE_07 - Hardware never alters own_slave_id and ignores it as master.
// RULE_08 - Slave mode compares upper seven id bits with first seven received bits.
// RULE_09 - Broadcast call 00h recognised only when broadcast_call_enable set.
// RULE_10 - Host programs an own id other than all zero.
// RULE_11 - own_slave_id resets to E0h.
// RULE_12 - Master holds SCL low scl_low_period oscillator periods of 35 ns.
// RULE_13 - Master holds SCL high scl_high_period oscillator periods.
// RULE_14 - Standard timing after reset; host sets speed before period registers.
// RULE_15 - Timeout active only while timeout_on bit 7 set.
// RULE_16 - Timeout lasts (timeout_count + 1) times about 143.36 us.
// RULE_17 - Timeout counter reloads on every falling SCL edge while operating.
// RULE_18 - SCL held low at START past timeout: status 78h, interrupt, release lines.
// RULE_19 - Master SCL low for timeout duration is bus error, same handling.
// RULE_20 - Host reads status then resets after timeout bus error.
// RULE_21 - Soft reset only on consecutive writes A5h then 5Ah; else aborted.
// RULE_22 - Period writes below speed-class minimum load the minimum.
// RULE_23 - Pointer selects register; data window accesses the selected one.
// RULE_24 - Speed field: 00 standard, 01 fast, 10 fast plus, 11 turbo.
// RULE_25 - Any access other than second key after first returns checker to idle; the code keeps it armed on a repeated A5h write.
`timescale 1ns/1ps
`default_nettype none
module i2c_ctrl_indirect_config_regs
  import cfg_regs_pkg::*;
#(
  parameter int TO_UNIT_CLKS = TO_UNIT_CYCLES
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Indirect window, index from the pointer register
  input  wire logic [2:0] idx,
  input  wire logic       wr,
  input  wire logic       rd,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata,
  // Core mode and state
  input  wire logic       buffered_mode,
  input  wire logic       receiving,
  input  wire logic       master_active,
  input  wire logic       start_pending,
  input  wire logic       bus_operating,
  input  wire logic       ctrl_written,
  input  wire logic       byte_stored,
  input  wire logic       last_byte_due,
  input  wire logic       addr_phase,
  input  wire logic [6:0] rx_addr,
  input  wire logic       scl_in,
  // Results to the core
  output logic      [6:0] tx_length,
  output logic            length_invalid_irq,
  output logic            ack_enable,
  output logic            slave_addressed,
  output logic            broadcast_hit,
  output logic      [7:0] low_ticks,
  output logic      [7:0] high_ticks,
  output logic      [1:0] timing_class,
  output logic            bus_error,
  output logic      [7:0] status_code,
  output logic            release_lines,
  output logic            soft_reset
);
  initial begin
    if (TO_UNIT_CLKS < 1) $error("TO_UNIT_CLKS must be at least one");
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchroniser for SCL
  logic scl_meta_r;
  logic scl_sync_r;
  logic scl_prev_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_meta_r <= 1'b1;
      scl_sync_r <= 1'b1;
      scl_prev_r <= 1'b1;
    end else begin
      scl_meta_r <= scl_in;
      scl_sync_r <= scl_meta_r;
      scl_prev_r <= scl_sync_r;
    end
  end
  logic scl_fall;
  assign scl_fall = scl_prev_r && !scl_sync_r;

  ////////////////////////////////////////////////////////////////////////
  // Register state
  logic       final_byte_nack_r, final_byte_nack_nxt;
  logic [6:0] transfer_length_r, transfer_length_nxt;
  logic [7:0] own_slave_id_r, own_slave_id_nxt;
  logic [7:0] scl_low_period_r, scl_low_period_nxt;
  logic [7:0] scl_high_period_r, scl_high_period_nxt;
  logic [7:0] stuck_low_timeout_r, stuck_low_timeout_nxt;
  logic [1:0] speed_select_r, speed_select_nxt;
  logic [6:0] rx_count_r, rx_count_nxt;
  logic       err_r, err_nxt;
  logic       irq_r, irq_nxt;
  logic       rst_pulse_r, rst_pulse_nxt;

  // Minimums for the current speed class
  logic [7:0] min_low;
  logic [7:0] min_high;
  always_comb begin
    unique case (speed_select_r)                                     // [RULE_24]
      SPEED_STANDARD:  begin min_low = MIN_LOW_STD; min_high = MIN_HIGH_STD; end
      SPEED_FAST:      begin min_low = MIN_LOW_FM;  min_high = MIN_HIGH_FM;  end
      SPEED_FAST_PLUS: begin min_low = MIN_LOW_FMP; min_high = MIN_HIGH_FMP; end
      SPEED_TURBO:     begin min_low = MIN_LOW_TRB; min_high = MIN_HIGH_TRB; end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Reset key checker
  typedef enum logic [1:0] {
    KEY_IDLE = 2'b01,
    KEY_ARMED = 2'b10
  } key_state_type;
  key_state_type key_r, key_nxt;

  always_comb begin
    key_nxt       = KEY_IDLE;
    rst_pulse_nxt = 1'b0;
    unique case (key_r)
      KEY_IDLE: begin
        if (wr && idx == IDX_RESET_KEY && wdata == KEY_FIRST) key_nxt = KEY_ARMED;
      end
      KEY_ARMED: begin
        // Any access except a repeated first key write ends the wait; only the matching write fires
        if (!(wr || rd)) key_nxt = KEY_ARMED;                        // [RULE_25]
        else if (wr && idx == IDX_RESET_KEY && wdata == KEY_SECOND)
          rst_pulse_nxt = 1'b1;                                      // [RULE_21]
        else if (wr && idx == IDX_RESET_KEY && wdata == KEY_FIRST)
          key_nxt = KEY_ARMED;
      end
      default: key_nxt = KEY_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Register writes and buffered-mode bookkeeping
  always_comb begin
    final_byte_nack_nxt   = final_byte_nack_r;
    transfer_length_nxt   = transfer_length_r;
    own_slave_id_nxt      = own_slave_id_r;                          // [RULE_07]
    scl_low_period_nxt    = scl_low_period_r;
    scl_high_period_nxt   = scl_high_period_r;
    stuck_low_timeout_nxt = stuck_low_timeout_r;
    speed_select_nxt      = speed_select_r;
    rx_count_nxt          = rx_count_r;
    if (wr) begin
      unique case (idx)
        IDX_BYTE_COUNT: begin
          final_byte_nack_nxt = wdata[TOP_BIT];
          transfer_length_nxt = wdata[6:0];
          rx_count_nxt        = ZERO_LENGTH;
        end
        IDX_OWN_ID:   own_slave_id_nxt = wdata;
        IDX_SCL_LOW:                                                 // [RULE_22]
          scl_low_period_nxt = (wdata < min_low) ? min_low : wdata;
        IDX_SCL_HIGH:
          scl_high_period_nxt = (wdata < min_high) ? min_high : wdata;
        IDX_TIMEOUT:  stuck_low_timeout_nxt = wdata;
        IDX_SPEED:    speed_select_nxt = wdata[1:0];
        default: ;
      endcase
    end
    // Receive count grows as the core stores bytes
    if (buffered_mode && receiving && byte_stored && rx_count_r < MAX_LENGTH)
      rx_count_nxt = rx_count_r + 1'b1;                              // [RULE_02]
    if (ctrl_written && buffered_mode && receiving)
      rx_count_nxt = ZERO_LENGTH;
  end

  ////////////////////////////////////////////////////////////////////////
  // Stuck-low timeout
  logic tick_unit;
  logic to_expired;
  logic to_run;
  // Timer armed only when enabled, operating, SCL low and master active or START pending
  assign to_run = stuck_low_timeout_r[TOP_BIT] && bus_operating    // [RULE_15]
                  && (master_active || start_pending) && !scl_sync_r;

  tick_divider #(.DIV(TO_UNIT_CLKS)) u_unit (
    .clk     (clk),
    .nrst    (nrst),
    .restart (scl_fall || !to_run),
    .tick    (tick_unit)
  );

  period_counter #(.WIDTH(7)) u_timeout (
    .clk        (clk),
    .nrst       (nrst),
    .load       (scl_fall),                                          // [RULE_17]
    .load_value (stuck_low_timeout_r[6:0]),                          // [RULE_16]
    .run        (to_run),
    .tick       (tick_unit),
    .expired    (to_expired)
  );

  always_comb begin
    err_nxt = err_r;
    // Error holds until the host resets the block
    // Expiry counts only while armed, so a soft reset that disarms cannot be undone
    if (to_expired && to_run) err_nxt = 1'b1;                        // [RULE_18] [RULE_19]
    irq_nxt = 1'b0;
    if (ctrl_written && buffered_mode &&
        (transfer_length_r == ZERO_LENGTH || transfer_length_r > MAX_LENGTH))
      irq_nxt = 1'b1;                                                // [RULE_03]
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      final_byte_nack_r   <= 1'b0;
      transfer_length_r   <= ZERO_LENGTH;
      own_slave_id_r      <= OWN_ID_RESET;                           // [RULE_11]
      scl_low_period_r    <= MIN_LOW_STD;
      scl_high_period_r   <= MIN_HIGH_STD;
      stuck_low_timeout_r <= ZERO_BYTE;
      speed_select_r      <= SPEED_STANDARD;                         // [RULE_14]
      rx_count_r          <= ZERO_LENGTH;
      err_r               <= 1'b0;
      irq_r               <= 1'b0;
      rst_pulse_r         <= 1'b0;
      key_r               <= KEY_IDLE;
    end else if (rst_pulse_r) begin
      final_byte_nack_r   <= 1'b0;
      transfer_length_r   <= ZERO_LENGTH;
      own_slave_id_r      <= OWN_ID_RESET;
      scl_low_period_r    <= MIN_LOW_STD;
      scl_high_period_r   <= MIN_HIGH_STD;
      stuck_low_timeout_r <= ZERO_BYTE;
      speed_select_r      <= SPEED_STANDARD;
      rx_count_r          <= ZERO_LENGTH;
      err_r               <= 1'b0;
      irq_r               <= 1'b0;
      rst_pulse_r         <= 1'b0;
      key_r               <= KEY_IDLE;
    end else begin
      final_byte_nack_r   <= final_byte_nack_nxt;
      transfer_length_r   <= transfer_length_nxt;
      own_slave_id_r      <= own_slave_id_nxt;
      scl_low_period_r    <= scl_low_period_nxt;
      scl_high_period_r   <= scl_high_period_nxt;
      stuck_low_timeout_r <= stuck_low_timeout_nxt;
      speed_select_r      <= speed_select_nxt;
      rx_count_r          <= rx_count_nxt;
      err_r               <= err_nxt;
      irq_r               <= irq_nxt;
      rst_pulse_r         <= rst_pulse_nxt;
      key_r               <= key_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data, registered; key register reads as zero
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  always_comb begin
    rdata_nxt = rdata_r;
    if (rd) begin                                                    // [RULE_23]
      unique case (idx)
        IDX_BYTE_COUNT: rdata_nxt = (buffered_mode && receiving)
                                    ? {final_byte_nack_r, rx_count_r}
                                    : {final_byte_nack_r, transfer_length_r};
        IDX_OWN_ID:   rdata_nxt = own_slave_id_r;
        IDX_SCL_LOW:  rdata_nxt = scl_low_period_r;
        IDX_SCL_HIGH: rdata_nxt = scl_high_period_r;
        IDX_TIMEOUT:  rdata_nxt = stuck_low_timeout_r;
        IDX_SPEED:    rdata_nxt = {6'h00, speed_select_r};
        default:      rdata_nxt = ZERO_BYTE;
      endcase
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) rdata_r <= ZERO_BYTE;
    else rdata_r <= rdata_nxt;
  end
  assign rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////
  // Outputs to the core
  assign tx_length          = transfer_length_r;                     // [RULE_01]
  assign length_invalid_irq = irq_r;
  // Final byte gets NACK only when flag set
  assign ack_enable = !(buffered_mode && receiving && last_byte_due
                        && final_byte_nack_r);                       // [RULE_04]
  // Own id unused while master
  assign slave_addressed = addr_phase && !master_active
                           && (rx_addr == own_slave_id_r[7:1]);      // [RULE_08] [RULE_07]
  assign broadcast_hit   = addr_phase && !master_active
                           && (rx_addr == ZERO_LENGTH)
                           && own_slave_id_r[0];                     // [RULE_09]
  assign low_ticks    = scl_low_period_r;                            // [RULE_12]
  assign high_ticks   = scl_high_period_r;                           // [RULE_13]
  assign timing_class = speed_select_r;
  assign bus_error     = err_r;
  assign status_code   = err_r ? STATUS_BUS_ERROR : ZERO_BYTE;
  assign release_lines = err_r;
  assign soft_reset    = rst_pulse_r;
endmodule : i2c_ctrl_indirect_config_regs
`default_nettype wire

// File: hdl/period_counter.sv
// Down counter that loads a count and flags expiry after count+1 ticks.
// Assumes tick is a single-cycle pulse in the clk domain.
`timescale 1ns/1ps
`default_nettype none
module period_counter #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // Control
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_value,
  input  wire logic             run,
  input  wire logic             tick,
  // Result
  output logic                  expired
);
  initial begin
    if (WIDTH < 1) $error("period_counter: WIDTH must be positive");
  end

  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;
  logic             done_r;
  logic             done_nxt;

  always_comb begin
    count_nxt = count_r;
    done_nxt  = done_r;
    if (load || !run) begin
      count_nxt = load_value;
      done_nxt  = 1'b0;
    end else if (tick && !done_r) begin
      if (count_r == '0) done_nxt = 1'b1;
      else count_nxt = count_r - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_r <= '0;
      done_r  <= 1'b0;
    end else begin
      count_r <= count_nxt;
      done_r  <= done_nxt;
    end
  end

  assign expired = done_r;
endmodule : period_counter
`default_nettype wire

// File: hdl/tick_divider.sv
// Divides clk into one-cycle ticks every DIV cycles.
// Assumes DIV of at least one.
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
  parameter int DIV = 2
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Control
  input  wire logic restart,
  // Tick out
  output logic      tick
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  initial begin
    if (DIV < 1) $error("tick_divider: DIV must be at least one");
  end

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;

  always_comb begin
    if (restart || cnt_r == LAST) cnt_nxt = '0;
    else cnt_nxt = cnt_r + 1'b1;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) cnt_r <= '0;
    else cnt_r <= cnt_nxt;
  end

  assign tick = !restart && (cnt_r == LAST);
endmodule : tick_divider
`default_nettype wire

// File: verification/cfg_regs_props.sv
// Concurrent checks on the indirect configuration register bank.
// Bound to every bank instance; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module cfg_regs_props
  import cfg_regs_pkg::*;
(
  // Clock, reset and host window
  input wire logic       clk, nrst, wr, rd,
  input wire logic [2:0] idx,
  input wire logic [7:0] wdata, rdata,
  // Core side
  input wire logic       buffered_mode, receiving, master_active, start_pending,
  input wire logic       bus_operating, ctrl_written, byte_stored, last_byte_due,
  input wire logic       addr_phase, scl_in, length_invalid_irq, ack_enable,
  input wire logic       slave_addressed, broadcast_hit, bus_error, release_lines, soft_reset,
  input wire logic [6:0] rx_addr, tx_length,
  input wire logic [7:0] low_ticks, high_ticks, status_code,
  input wire logic [1:0] timing_class
);
  logic armed_r;
  logic armed_nxt;
  logic key_hit;
  assign key_hit = wr && idx == IDX_RESET_KEY && wdata == KEY_SECOND && armed_r;
  // Any window access disarms, except the first key byte itself
  always_comb begin
    armed_nxt = armed_r;
    if (wr || rd) begin
      armed_nxt = wr && idx == IDX_RESET_KEY && wdata == KEY_FIRST;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      armed_r <= 1'b0;
    end else begin
      armed_r <= armed_nxt;
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_key_fires: assert property (key_hit |=> soft_reset)
    else $error("soft reset missing after key pair");
  chk_key_only: assert property (!key_hit |=> !soft_reset)
    else $error("soft reset without key pair");
  chk_len_irq: assert property (ctrl_written && buffered_mode &&
      (tx_length == 7'h00 || tx_length > 7'h44) |=> length_invalid_irq)
    else $error("length interrupt missing");
  chk_irq_cause: assert property (length_invalid_irq |->
      $past(ctrl_written) && $past(buffered_mode))
    else $error("length interrupt without cause");
  chk_own_master: assert property (slave_addressed |-> !master_active)
    else $error("own id used as master");
  chk_bcast_zero: assert property (broadcast_hit |-> rx_addr == 7'h00)
    else $error("broadcast hit on nonzero address");
  chk_err_report: assert property (bus_error |->
      status_code == 8'h78 && release_lines)
    else $error("bus error report wrong");
  chk_err_scl: assert property ($rose(bus_error) |-> !$past(scl_in, 3))
    else $error("bus error with clock line high");
  chk_rdata_hold: assert property (!rd && !soft_reset |=> $stable(rdata))
    else $error("read data moved without read");
  cover property (soft_reset);
  cover property (length_invalid_irq);
  cover property (bus_error);
endmodule : cfg_regs_props
bind i2c_ctrl_indirect_config_regs cfg_regs_props u_props (.*);
`default_nettype wire

// File: verification/host_model.sv
// Host side of the indirect window: pointer plus data strobes.
// Drives at the falling edge; one idle cycle between accesses.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock and read data
  input  wire logic       clk,
  input  wire logic [7:0] rdata,
  // Window
  output var  logic [2:0] idx,
  output var  logic       wr,
  output var  logic       rd,
  output var  logic [7:0] wdata
);
  initial begin
    idx = 3'h0;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 8'h00;
  end
  // Pointer goes out with the window strobe
  task automatic put(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    idx = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    // Released data inverted so a stale byte never looks valid
    wdata = ~d;
  endtask : put
  task automatic get(input logic [2:0] a, output logic [7:0] d);
    @(negedge clk);
    idx = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    d = rdata;
  endtask : get
endmodule : host_model
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench for the indirect configuration register bank.
// Host model drives the window; core levels change at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module testbench import cfg_regs_pkg::*;;
  logic       clk, nrst, wr, rd, buffered_mode, receiving, master_active, start_pending;
  logic       bus_operating, ctrl_written, byte_stored, last_byte_due, addr_phase, scl_in;
  logic       length_invalid_irq, ack_enable, slave_addressed, broadcast_hit, bus_error;
  logic       release_lines, soft_reset, seen;
  logic [2:0] idx;
  logic [6:0] rx_addr, tx_length;
  logic [7:0] wdata, rdata, low_ticks, high_ticks, status_code, v;
  logic [1:0] timing_class;
  int         err_count, compares;
  i2c_ctrl_indirect_config_regs #(.TO_UNIT_CLKS(4)) dut (.*);
  host_model host (.clk(clk), .rdata(rdata), .idx(idx), .wr(wr), .rd(rd), .wdata(wdata));
  always #12.5 clk = ~clk;
  ////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic close_out;
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out
  task automatic pulse_ctrl;
    @(negedge clk);
    ctrl_written = 1'b1;
    @(negedge clk);
    ctrl_written = 1'b0;
  endtask : pulse_ctrl
  task automatic watch;
    seen = soft_reset;
    repeat (2) begin
      @(negedge clk);
      seen = seen | soft_reset;
    end
  endtask : watch
  task automatic probe(input logic ma, input logic [6:0] ra, input logic [7:0] exp);
    @(negedge clk);
    master_active = ma;
    rx_addr = ra;
    #1;
    chk("match flags", exp, {6'h00, slave_addressed, broadcast_hit});
  endtask : probe
  ////////////////////////////////////////////////////////////
  task automatic t_reset_values;
    logic [7:0] exp [8];
    exp = '{8'h00, 8'hE0, 8'h9D, 8'h86, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++) begin
      host.get(3'(i), v);
      chk("reset value", exp[i], v);
    end
    host.put(3'h7, 8'h3C);
    host.get(3'h7, v);
    chk("unmapped", 8'h00, v);
  endtask : t_reset_values
  task automatic t_clamp;
    logic [7:0] lo [4];
    logic [7:0] hi [4];
    lo = '{8'h9D, 8'h2C, 8'h11, 8'h0E};
    hi = '{8'h86, 8'h14, 8'h09, 8'h05};
    for (int c = 0; c < 4; c++) begin
      host.put(IDX_SPEED, 8'(c));
      host.put(IDX_SCL_LOW, 8'h01);
      host.put(IDX_SCL_HIGH, 8'h00);
      chk("class", 8'(c), {6'h00, timing_class});
      chk("low clamp", lo[c], low_ticks);
      chk("high clamp", hi[c], high_ticks);
    end
    host.put(IDX_SCL_LOW, 8'hC8);
    host.put(IDX_SCL_HIGH, 8'h77);
    chk("low ticks", 8'hC8, low_ticks);
    chk("high ticks", 8'h77, high_ticks);
  endtask : t_clamp
  task automatic t_length;
    logic [6:0] len [5];
    len = '{7'h00, 7'h01, 7'h44, 7'h45, 7'h7F};
    for (int i = 0; i < 5; i++) begin
      host.put(IDX_BYTE_COUNT, {1'b0, len[i]});
      chk("length", {1'b0, len[i]}, {1'b0, tx_length});
      pulse_ctrl;
      chk("length irq", 8'(len[i] == 7'h00 || len[i] > 7'h44), 8'(length_invalid_irq));
    end
    buffered_mode = 1'b0;
    pulse_ctrl;
    chk("byte mode irq", 8'h00, 8'(length_invalid_irq));
    buffered_mode = 1'b1;
  endtask : t_length
  task automatic t_receive;
    receiving = 1'b1;
    last_byte_due = 1'b1;
    host.put(IDX_BYTE_COUNT, 8'h83);
    chk("ack, nack set", 8'h00, 8'(ack_enable));
    host.put(IDX_BYTE_COUNT, 8'h03);
    chk("ack, nack clear", 8'h01, 8'(ack_enable));
    pulse_ctrl;
    repeat (2) begin
      @(negedge clk);
      byte_stored = 1'b1;
      @(negedge clk);
      byte_stored = 1'b0;
    end
    host.get(IDX_BYTE_COUNT, v);
    chk("stored count", 8'h02, {1'b0, v[6:0]});
    receiving = 1'b0;
    last_byte_due = 1'b0;
  endtask : t_receive
  task automatic t_address;
    addr_phase = 1'b1;
    host.put(IDX_OWN_ID, 8'hA3);
    probe(1'b0, 7'h51, 8'h02);
    probe(1'b0, 7'h50, 8'h00);
    probe(1'b0, 7'h00, 8'h01);
    probe(1'b1, 7'h51, 8'h00);
    host.put(IDX_OWN_ID, 8'hA2);
    probe(1'b0, 7'h00, 8'h00);
    host.get(IDX_OWN_ID, v);
    chk("own id kept", 8'hA2, v);
    addr_phase = 1'b0;
  endtask : t_address
  task automatic t_timeout;
    int n;
    master_active = 1'b1;
    bus_operating = 1'b1;
    host.put(IDX_TIMEOUT, 8'h02);
    scl_in = 1'b0;
    repeat (40) @(negedge clk);
    chk("error, disabled", 8'h00, 8'(bus_error));
    host.put(IDX_TIMEOUT, 8'h82);
    repeat (6) begin
      scl_in = 1'b1;
      @(negedge clk);
      scl_in = 1'b0;
      repeat (6) @(negedge clk);
    end
    chk("error, toggling", 8'h00, 8'(bus_error));
    scl_in = 1'b1;
    @(negedge clk);
    scl_in = 1'b0;
    n = 0;
    while (bus_error !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    // Three units of four clocks, plus synchroniser latency
    chk("timeout span", 8'h01, 8'(n >= 12 && n <= 20));
    chk("status", 8'h78, status_code);
    chk("release", 8'h01, 8'(release_lines));
    master_active = 1'b0;
    bus_operating = 1'b0;
    scl_in = 1'b1;
  endtask : t_timeout
  task automatic t_key;
    host.put(IDX_RESET_KEY, 8'hA5);
    host.get(IDX_RESET_KEY, v);
    chk("write-only read", 8'h00, v);
    host.put(IDX_RESET_KEY, 8'h5A);
    watch;
    chk("reset, read between", 8'h00, 8'(seen));
    host.put(IDX_RESET_KEY, 8'hA5);
    host.put(IDX_RESET_KEY, 8'h5B);
    host.put(IDX_RESET_KEY, 8'h5A);
    watch;
    chk("reset, bad key", 8'h00, 8'(seen));
    host.put(IDX_RESET_KEY, 8'hA5);
    host.put(IDX_RESET_KEY, 8'h5A);
    watch;
    chk("soft reset", 8'h01, 8'(seen));
    chk("error cleared", 8'h00, 8'(bus_error));
    host.get(IDX_OWN_ID, v);
    chk("own id restored", 8'hE0, v);
  endtask : t_key
  task automatic t_start_wait;
    start_pending = 1'b1;
    bus_operating = 1'b1;
    scl_in = 1'b0;
    host.put(IDX_TIMEOUT, 8'h80);
    repeat (12) @(negedge clk);
    chk("start wait error", 8'h78, status_code);
  endtask : t_start_wait
  ////////////////////////////////////////////////////////////
  initial begin
    #100000;
    err_count++;
    close_out;
  end
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    buffered_mode = 1'b1;
    receiving = 1'b0;
    master_active = 1'b0;
    start_pending = 1'b0;
    bus_operating = 1'b0;
    ctrl_written = 1'b0;
    byte_stored = 1'b0;
    last_byte_due = 1'b0;
    addr_phase = 1'b0;
    rx_addr = 7'h00;
    scl_in = 1'b1;
    err_count = 0;
    compares = 0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    t_reset_values;
    t_clamp;
    t_length;
    t_receive;
    t_address;
    t_timeout;
    t_key;
    t_start_wait;
    close_out;
  end
endmodule : testbench
`default_nettype wire
